// [bcd_addr_decode.sv]
// Purpose: combinational address decode into regions and flash areas
// Assumes: 32-bit byte address
// Notes:   reserved holes decode to none
`timescale 1ns/1ps
`include "bcd_boot_config_map.svh"

module bcd_addr_decode
  import bcd_pkg::*;
(
  input wire logic [31:0] addr_in,
  output bcd_region_t region_out,
  output bcd_area_t area_out
);

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  // lower code bound is zero, so only the top is compared
  always_comb begin
    region_out = bcd_rg_none;
    if (addr_in <= `BCD_CODE_HI) begin
      region_out = bcd_rg_code;
    end else if (addr_in >= `BCD_SRAM_LO && addr_in <= `BCD_SRAM_HI) begin
      region_out = bcd_rg_sram;
    end else if (addr_in >= `BCD_PERIPH_LO && addr_in <= `BCD_PERIPH_HI) begin
      region_out = bcd_rg_periph;
    end else if (addr_in >= `BCD_PRIV_LO && addr_in <= `BCD_PRIV_HI) begin
      region_out = bcd_rg_priv;
    end
  end

  // ----------------------------------------------------------------
  // flash area decode
  // ----------------------------------------------------------------
  always_comb begin
    area_out = bcd_ar_none;
    if (addr_in <= `BCD_PROG_HI) begin
      area_out = bcd_ar_prog;
    end else if (addr_in >= `BCD_DFLASH_LO && addr_in <= `BCD_DFLASH_HI) begin
      area_out = bcd_ar_dflash;
    end else if (addr_in >= `BCD_BOOT_LO && addr_in <= `BCD_BOOT_HI) begin
      area_out = bcd_ar_boot;
    end else if (addr_in >= `BCD_INFO_LO && addr_in <= `BCD_INFO_HI) begin
      area_out = bcd_ar_info;
    end
  end

endmodule

// [bcd_boot_config.sv]
// Purpose: registered address decode plus boot config word loader
// Assumes: flash answers a fetch with one-cycle ack and data
// Notes:   defaults drive the startup controls until the word is applied
`timescale 1ns/1ps
`include "bcd_boot_config_map.svh"

// Functional notes
// - low 512KB goes to code flash
// - sram data region up to 0x20007fff
// - peripheral and core private bus windows
// - program flash up to 0x0003e7ff
// - 2KB data flash area
// - 4KB bootloader area
// - 1KB config info area, rest reserved
// - fetch config word at 0x00040010
// - bit 3 enables reset pin, default off
// - bits 4 and 6 debug, boot; default on
// - bit 7 zero refuses programmer readout
// - bits 31..28 must read 0101
module bcd_boot_config
  import bcd_pkg::*;
#(
  parameter int unsigned FETCH_TIMEOUT = `BCD_FETCH_TIMEOUT_CYC
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic addr_valid_in,
  input wire logic [31:0] addr_in,
  output logic code_sel_out,
  output logic sram_sel_out,
  output logic periph_sel_out,
  output logic core_private_bus_sel_out,
  output logic unmapped_out,
  output logic user_program_flash_sel_out,
  output logic user_data_flash_sel_out,
  output logic boot_flash_sel_out,
  output logic system_config_flash_sel_out,
  output logic cfg_req_out,
  output logic [31:0] cfg_addr_out,
  input wire logic cfg_ack_in,
  input wire logic [31:0] cfg_data_in,
  output logic cfg_done_out,
  output logic cfg_valid_out,
  output logic pin_reset_en_out,
  output logic debug_en_out,
  output logic bootloader_en_out,
  output logic readout_allowed_out,
  input wire logic reset_pin_n_in,
  output logic ext_reset_out,
  input wire logic prog_read_req_in,
  output logic prog_read_grant_out,
  output logic prog_read_refuse_out
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (FETCH_TIMEOUT < 1 || FETCH_TIMEOUT > 65535) begin : g_bad_timeout
    $error("FETCH_TIMEOUT must be 1..65535");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  bcd_region_t region; // decoded region of addr_in
  bcd_area_t area; // decoded flash area of addr_in

  bcd_addr_decode u_decode (
    .addr_in(addr_in),
    .region_out(region),
    .area_out(area)
  );

  // selects are registered; all low when no address is offered
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      code_sel_out <= 1'b0;
      sram_sel_out <= 1'b0;
      periph_sel_out <= 1'b0;
      core_private_bus_sel_out <= 1'b0;
      unmapped_out <= 1'b0;
    end else begin
      code_sel_out <= addr_valid_in && region == bcd_rg_code;
      sram_sel_out <= addr_valid_in && region == bcd_rg_sram;
      periph_sel_out <= addr_valid_in && region == bcd_rg_periph;
      core_private_bus_sel_out <= addr_valid_in && region == bcd_rg_priv;
      // reserved holes flagged so the bus can fault
      unmapped_out <= addr_valid_in && region == bcd_rg_none;
    end
  end

  // flash area selects, one hot or none
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      user_program_flash_sel_out <= 1'b0;
      user_data_flash_sel_out <= 1'b0;
      boot_flash_sel_out <= 1'b0;
      system_config_flash_sel_out <= 1'b0;
    end else begin
      user_program_flash_sel_out <= addr_valid_in && area == bcd_ar_prog;
      user_data_flash_sel_out <= addr_valid_in && area == bcd_ar_dflash;
      boot_flash_sel_out <= addr_valid_in && area == bcd_ar_boot;
      system_config_flash_sel_out <= addr_valid_in && area == bcd_ar_info;
    end
  end

  // ----------------------------------------------------------------
  // config word loader
  // ----------------------------------------------------------------
  bcd_state_t state; // loader state
  logic [15:0] wait_cnt; // cycles spent waiting for ack
  logic sig_ok; // config_valid_pattern present in fetched word
  logic timed_out; // flash never answered

  assign sig_ok = cfg_data_in[`BCD_CFG_SIG_HI:`BCD_CFG_SIG_LO] == `BCD_CFG_VALID_PATTERN;
  assign timed_out = wait_cnt == 16'(FETCH_TIMEOUT - 1);

  // request the fixed word address while fetching
  assign cfg_req_out = state == bcd_st_fetch;
  assign cfg_addr_out = `BCD_CFG_WORD_ADDR;

  // state and wait counter; a dead flash must not hang startup
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= bcd_st_fetch;
      wait_cnt <= 16'h0000;
    end else begin
      unique case (state)
        bcd_st_fetch: begin
          wait_cnt <= wait_cnt + 16'h0001;
          if (cfg_ack_in || timed_out) begin
            state <= bcd_st_done;
          end
        end
        bcd_st_done: begin
          state <= bcd_st_done;
        end
      endcase
    end
  end

  // startup control bits; defaults hold until a good word lands
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_reset_en_out <= `BCD_DEF_RESET_EN;
      debug_en_out <= `BCD_DEF_DEBUG_EN;
      bootloader_en_out <= `BCD_DEF_BOOT_EN;
      readout_allowed_out <= `BCD_DEF_READ_EN;
      cfg_valid_out <= 1'b0;
      cfg_done_out <= 1'b0;
    end else if (state == bcd_st_fetch && (cfg_ack_in || timed_out)) begin
      cfg_done_out <= 1'b1;
      // only a word carrying the pattern is trusted
      if (cfg_ack_in && sig_ok) begin
        cfg_valid_out <= 1'b1;
        pin_reset_en_out <= cfg_data_in[`BCD_CFG_RESET_BIT];
        debug_en_out <= cfg_data_in[`BCD_CFG_DEBUG_BIT];
        bootloader_en_out <= cfg_data_in[`BCD_CFG_BOOT_BIT];
        readout_allowed_out <= cfg_data_in[`BCD_CFG_READ_BIT];
      end else begin
        // invalid or missing word, keep defaults
        cfg_valid_out <= 1'b0;
        pin_reset_en_out <= `BCD_DEF_RESET_EN;
        debug_en_out <= `BCD_DEF_DEBUG_EN;
        bootloader_en_out <= `BCD_DEF_BOOT_EN;
        readout_allowed_out <= `BCD_DEF_READ_EN;
      end
    end
  end

  // ----------------------------------------------------------------
  // external reset pin
  // ----------------------------------------------------------------
  logic [2:0] pin_sync; // pin synchroniser, [0] read only by [1]
  logic pin_low; // filtered pin level, high when pin held low

  // three-stage sync; pin is asynchronous to clock_in
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_sync <= 3'h7;
    end else begin
      pin_sync <= {pin_sync[1:0], reset_pin_n_in};
    end
  end

  // level accepted only when stages two and three agree
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_low <= 1'b0;
    end else if (pin_sync[1] == pin_sync[2]) begin
      pin_low <= ~pin_sync[2];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ext_reset_out <= 1'b0;
    end else begin
      ext_reset_out <= pin_reset_en_out && pin_low;
    end
  end

  // ----------------------------------------------------------------
  // programmer readout gate
  // ----------------------------------------------------------------
  // refuse readout when protected or not yet loaded
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prog_read_grant_out <= 1'b0;
      prog_read_refuse_out <= 1'b0;
    end else begin
      prog_read_grant_out <= prog_read_req_in && cfg_done_out && readout_allowed_out;
      prog_read_refuse_out <= prog_read_req_in && !(cfg_done_out && readout_allowed_out);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_code_route: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in && addr_in <= `BCD_CODE_HI |=> code_sel_out && !unmapped_out)
    else $error("code address not routed to code region");

  a_sram_route: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in && addr_in >= `BCD_SRAM_LO && addr_in <= `BCD_SRAM_HI
    |=> sram_sel_out && !code_sel_out)
    else $error("sram address not routed to sram");

  a_periph_priv: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in |=> (periph_sel_out == ($past(addr_in) >= `BCD_PERIPH_LO
    && $past(addr_in) <= `BCD_PERIPH_HI)) && (core_private_bus_sel_out ==
    ($past(addr_in) >= `BCD_PRIV_LO && $past(addr_in) <= `BCD_PRIV_HI)))
    else $error("peripheral or private bus decode wrong");

  a_prog_area: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in && addr_in == `BCD_PROG_HI |=> user_program_flash_sel_out)
    else $error("top of program flash not selected");

  a_dflash_area: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in && addr_in >= `BCD_DFLASH_LO && addr_in <= `BCD_DFLASH_HI
    |=> user_data_flash_sel_out && !user_program_flash_sel_out)
    else $error("data flash area not selected");

  a_boot_area: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in && addr_in >= `BCD_BOOT_LO && addr_in <= `BCD_BOOT_HI
    |=> boot_flash_sel_out)
    else $error("bootloader area not selected");

  a_info_area: assert property (@(posedge clock_in) disable iff (rst_in)
    addr_valid_in && addr_in > `BCD_INFO_HI && addr_in <= `BCD_CODE_HI
    |=> code_sel_out && !system_config_flash_sel_out && !user_program_flash_sel_out)
    else $error("reserved code space selected a flash area");

  a_fetch_addr: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_req_out |-> cfg_addr_out == `BCD_CFG_WORD_ADDR && !cfg_done_out)
    else $error("config fetch at wrong address");

  a_reset_pin: assert property (@(posedge clock_in) disable iff (rst_in)
    ext_reset_out |-> $past(pin_reset_en_out) && $past(pin_low))
    else $error("reset pin acted while disabled");

  a_good_word: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_req_out && cfg_ack_in && sig_ok |=> cfg_valid_out
    && debug_en_out == $past(cfg_data_in[`BCD_CFG_DEBUG_BIT])
    && bootloader_en_out == $past(cfg_data_in[`BCD_CFG_BOOT_BIT]))
    else $error("valid config word not applied");

  a_readout_block: assert property (@(posedge clock_in) disable iff (rst_in)
    prog_read_req_in && !readout_allowed_out |=> prog_read_refuse_out && !prog_read_grant_out)
    else $error("protected flash readout granted");

  a_bad_sig: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_req_out && cfg_ack_in && !sig_ok |=> cfg_done_out && !cfg_valid_out
    && !pin_reset_en_out && debug_en_out && bootloader_en_out && readout_allowed_out)
    else $error("invalid config word not replaced by defaults");

  a_valid_pattern: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(cfg_valid_out) |-> $past(cfg_ack_in) && $past(sig_ok))
    else $error("config marked valid without the pattern");

  // cycles since reset, saturating; lets the load bound follow FETCH_TIMEOUT
  logic [16:0] boot_age; // wide enough for the largest legal timeout
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      boot_age <= 17'h00000;
    end else if (boot_age != 17'h1ffff) begin
      boot_age <= boot_age + 17'h00001;
    end
  end

  a_load_bound: assert property (@(posedge clock_in) disable iff (rst_in)
    boot_age >= 17'(FETCH_TIMEOUT) |-> cfg_done_out)
    else $error("config load did not finish");

endmodule

// [bcd_boot_config_map.svh]
// Purpose: address map, config word layout and defaults for the boot config block
// Assumes: byte addresses on a 32-bit system bus
// Notes:   definitions only, included by the modules
`ifndef BCD_BOOT_CONFIG_MAP_SVH
`define BCD_BOOT_CONFIG_MAP_SVH

// ----------------------------------------------------------------
// system regions
// ----------------------------------------------------------------
`define BCD_CODE_HI 32'h0007_ffff
`define BCD_SRAM_LO 32'h2000_0000
`define BCD_SRAM_HI 32'h2000_7fff
`define BCD_PERIPH_LO 32'h4000_0000
`define BCD_PERIPH_HI 32'h4000_ffff
`define BCD_PRIV_LO 32'he000_0000
`define BCD_PRIV_HI 32'he000_ffff

// ----------------------------------------------------------------
// flash areas inside the code region
// ----------------------------------------------------------------
`define BCD_PROG_HI 32'h0003_e7ff
`define BCD_DFLASH_LO 32'h0003_e800
`define BCD_DFLASH_HI 32'h0003_efff
`define BCD_BOOT_LO 32'h0003_f000
`define BCD_BOOT_HI 32'h0003_ffff
`define BCD_INFO_LO 32'h0004_0000
`define BCD_INFO_HI 32'h0004_03ff

// ----------------------------------------------------------------
// user configuration word
// ----------------------------------------------------------------
`define BCD_CFG_WORD_ADDR 32'h0004_0010
`define BCD_CFG_RESET_BIT 3
`define BCD_CFG_DEBUG_BIT 4
`define BCD_CFG_BOOT_BIT 6
`define BCD_CFG_READ_BIT 7
`define BCD_CFG_SIG_HI 31
`define BCD_CFG_SIG_LO 28
`define BCD_CFG_VALID_PATTERN 4'h5
`define BCD_DEF_RESET_EN 1'h0
`define BCD_DEF_DEBUG_EN 1'h1
`define BCD_DEF_BOOT_EN 1'h1
`define BCD_DEF_READ_EN 1'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BCD_FETCH_TIMEOUT_CYC 256

`endif

// [bcd_flash_model.sv]
// Purpose: flash side of the config fetch, answers one word per reset
// Assumes: request level from the loader, one-cycle ack with data
// Notes:   data bus toggles while released so stale values never look valid
`timescale 1ns/1ps

module bcd_flash_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cfg_req_in,
  input wire logic [31:0] cfg_addr_in,
  input wire logic [31:0] word_in,
  input wire logic [3:0] delay_in,
  input wire logic silent_in,
  output logic cfg_ack_out,
  output logic [31:0] cfg_data_out
);
  // ----------------------------------------------------------------
  // answer logic
  // ----------------------------------------------------------------
  logic [3:0] wait_cnt; // cycles spent before answering
  logic answered; // one answer per reset only

  // slow or silent flash is chosen by the bench per boot
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wait_cnt <= 4'h0;
      answered <= 1'b0;
      cfg_ack_out <= 1'b0;
      cfg_data_out <= 32'h0;
    end else begin
      cfg_ack_out <= 1'b0;
      // released bus: inverse of last value, never a held copy
      cfg_data_out <= ~cfg_data_out;
      if (cfg_req_in && !answered && !silent_in) begin
        if (wait_cnt == delay_in) begin
          cfg_ack_out <= 1'b1;
          answered <= 1'b1;
          cfg_data_out <= (cfg_addr_in === 32'h0004_0010) ? word_in : ~word_in;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

// [bcd_pkg.sv]
// Purpose: shared types of the boot config block
// Assumes: nothing beyond the map header
// Notes:   enums carry no explicit codes
package bcd_pkg;

  // ----------------------------------------------------------------
  // decode results
  // ----------------------------------------------------------------
  // top-level system region
  typedef enum logic [2:0] {
    bcd_rg_none,
    bcd_rg_code,
    bcd_rg_sram,
    bcd_rg_periph,
    bcd_rg_priv
  } bcd_region_t;

  // flash area within the code region
  typedef enum logic [2:0] {
    bcd_ar_none,
    bcd_ar_prog,
    bcd_ar_dflash,
    bcd_ar_boot,
    bcd_ar_info
  } bcd_area_t;

  // config loader states
  typedef enum logic [1:0] {
    bcd_st_fetch,
    bcd_st_done
  } bcd_state_t;

endpackage

// [tb.sv]
// Purpose: self-checking bench for the boot config and address decode block
// Assumes: short fetch timeout of 8 cycles
// Notes:   decode and read results go through a queue of expected notes
`timescale 1ns/1ps

module tb;
  import bcd_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic addr_valid_in = 1'b0;
  logic [31:0] addr_in = 32'h0;
  logic reset_pin_n_in = 1'b1;
  logic prog_read_req_in = 1'b0;
  logic cfg_ack_in, cfg_req_out, cfg_done_out, cfg_valid_out, ext_reset_out;
  logic [31:0] cfg_data_in, cfg_addr_out;
  logic code_sel_out, sram_sel_out, periph_sel_out, core_private_bus_sel_out, unmapped_out;
  logic user_program_flash_sel_out, user_data_flash_sel_out, boot_flash_sel_out;
  logic system_config_flash_sel_out, prog_read_grant_out, prog_read_refuse_out;
  logic pin_reset_en_out, debug_en_out, bootloader_en_out, readout_allowed_out;
  logic [31:0] m_word = 32'h0; // word the flash holds
  logic [3:0] m_delay = 4'h0; // flash answer delay
  logic m_silent = 1'b0; // flash never answers
  logic [31:0] seed = 32'h0001_0b6f;
  logic read_ok = 1'b0; // expected readout permission
  logic [10:0] notes[$]; // expected selects, grant, refuse
  int bad_count = 0;
  int cmp_count = 0;

  // free-running system clock, 100 ns
  always #50 clock_in = ~clock_in;

  bcd_boot_config #(.FETCH_TIMEOUT(8)) dut (.clock_in(clock_in), .rst_in(rst_in),
    .addr_valid_in(addr_valid_in), .addr_in(addr_in), .code_sel_out(code_sel_out),
    .sram_sel_out(sram_sel_out), .periph_sel_out(periph_sel_out),
    .core_private_bus_sel_out(core_private_bus_sel_out), .unmapped_out(unmapped_out),
    .user_program_flash_sel_out(user_program_flash_sel_out),
    .user_data_flash_sel_out(user_data_flash_sel_out), .boot_flash_sel_out(boot_flash_sel_out),
    .system_config_flash_sel_out(system_config_flash_sel_out), .cfg_req_out(cfg_req_out),
    .cfg_addr_out(cfg_addr_out), .cfg_ack_in(cfg_ack_in), .cfg_data_in(cfg_data_in),
    .cfg_done_out(cfg_done_out), .cfg_valid_out(cfg_valid_out),
    .pin_reset_en_out(pin_reset_en_out), .debug_en_out(debug_en_out),
    .bootloader_en_out(bootloader_en_out), .readout_allowed_out(readout_allowed_out),
    .reset_pin_n_in(reset_pin_n_in), .ext_reset_out(ext_reset_out),
    .prog_read_req_in(prog_read_req_in), .prog_read_grant_out(prog_read_grant_out),
    .prog_read_refuse_out(prog_read_refuse_out));

  bcd_flash_model flash (.clock_in(clock_in), .rst_in(rst_in), .cfg_req_in(cfg_req_out),
    .cfg_addr_in(cfg_addr_out), .word_in(m_word), .delay_in(m_delay), .silent_in(m_silent),
    .cfg_ack_out(cfg_ack_in), .cfg_data_out(cfg_data_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected region and area bits for one address
  function automatic logic [8:0] exp_dec(input logic [31:0] a);
    logic c, s, p, v;
    c = (a <= 32'h0007_ffff);
    s = (a >= 32'h2000_0000) && (a <= 32'h2000_7fff);
    p = (a >= 32'h4000_0000) && (a <= 32'h4000_ffff);
    v = (a >= 32'he000_0000) && (a <= 32'he000_ffff);
    return {c, s, p, v, !(c | s | p | v), a <= 32'h0003_e7ff,
      (a >= 32'h0003_e800) && (a <= 32'h0003_efff),
      (a >= 32'h0003_f000) && (a <= 32'h0003_ffff),
      (a >= 32'h0004_0000) && (a <= 32'h0004_03ff)};
  endfunction

  // random address near a mapped window, holes included
  function automatic logic [31:0] pick_addr();
    logic [31:0] r;
    r = xs();
    case (r[31:30])
      2'h0: return {12'h000, r[19:0]};
      2'h1: return 32'h2000_0000 | {16'h0, r[15:0]};
      2'h2: return 32'h4000_0000 | {15'h0, r[16:0]};
      default: return 32'he000_0000 | {15'h0, r[16:0]};
    endcase
  endfunction

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // inputs move a fixed 2 ns after the edge
  task automatic tick();
    @(posedge clock_in);
    #2;
  endtask

  // one cycle of stimulus, noting what must show one cycle later
  task automatic drive(input logic v, input logic [31:0] a, input logic p);
    tick();
    addr_valid_in = v;
    addr_in = a;
    prog_read_req_in = p;
    if (v || p) begin
      notes.push_back({v ? exp_dec(a) : 9'h0, p & read_ok, p & !read_ok});
    end
  endtask

  // reset, fetch the word, then check enables, readout and the reset pin
  task automatic run_boot(input logic [31:0] w, input logic [3:0] d, input logic s,
                          input int hold);
    logic ok, er, ed, eb, erd;
    int n;
    // let the last noted result show before reset hides it from the watcher
    repeat (2) drive(1'b0, 32'h0, 1'b0);
    m_word = w;
    m_delay = d;
    m_silent = s;
    rst_in = 1'b1;
    repeat (hold) tick();
    rst_in = 1'b0;
    read_ok = 1'b0;
    drive(1'b1, pick_addr(), 1'b1);
    check(32'({cfg_done_out, pin_reset_en_out, debug_en_out, bootloader_en_out,
      readout_allowed_out}), 32'h0000_0007);
    for (n = 0; n < 40 && cfg_done_out !== 1'b1; n++) begin
      drive(1'b1, pick_addr(), 1'b0);
    end
    if (n == 40) begin
      bad_count++;
      report_and_stop();
    end
    ok = !s && (w[31:28] == 4'h5);
    er = ok ? w[3] : 1'b0;
    ed = ok ? w[4] : 1'b1;
    eb = ok ? w[6] : 1'b1;
    erd = ok ? w[7] : 1'b1;
    check(32'({cfg_valid_out, pin_reset_en_out, debug_en_out, bootloader_en_out,
      readout_allowed_out, cfg_req_out}), 32'({ok, er, ed, eb, erd, 1'b0}));
    check(cfg_addr_out, 32'h0004_0010);
    read_ok = erd;
    drive(1'b0, 32'h0, 1'b1);
    drive(1'b0, 32'h0, 1'b1);
    drive(1'b0, 32'h0, 1'b0);
    reset_pin_n_in = 1'b0;
    repeat (5) tick();
    check(32'(ext_reset_out), 32'(er));
    reset_pin_n_in = 1'b1;
    repeat (5) tick();
    check(32'(ext_reset_out), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // result watcher: each result takes the oldest note
  // ----------------------------------------------------------------
  logic [10:0] got;
  assign got = {code_sel_out, sram_sel_out, periph_sel_out, core_private_bus_sel_out,
    unmapped_out, user_program_flash_sel_out, user_data_flash_sel_out, boot_flash_sel_out,
    system_config_flash_sel_out, prog_read_grant_out, prog_read_refuse_out};

  always @(negedge clock_in) begin
    if (!rst_in && got !== 11'h0) begin
      if (notes.size() == 0) begin
        check(32'h0, 32'(got));
      end else begin
        check(32'(notes.pop_front()), 32'(got));
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [31:0] bnd[23] = '{32'h0, 32'h0003_e7ff, 32'h0003_e800, 32'h0003_efff,
    32'h0003_f000, 32'h0003_ffff, 32'h0004_0000, 32'h0004_03ff, 32'h0004_0400,
    32'h0007_ffff, 32'h0008_0000, 32'h1fff_ffff, 32'h2000_0000, 32'h2000_7fff,
    32'h2000_8000, 32'h4000_0000, 32'h4000_ffff, 32'h4001_0000, 32'hdfff_ffff,
    32'he000_0000, 32'he000_ffff, 32'he001_0000, 32'hffff_ffff};

  initial begin
    logic [31:0] w;
    run_boot(32'h5000_00d8, 4'h0, 1'b0, 12);
    foreach (bnd[i]) drive(1'b1, bnd[i], (i % 3) == 0);
    run_boot(32'h5000_0000, 4'h2, 1'b0, 2);
    foreach (bnd[i]) drive(1'b1, bnd[i], (i % 2) == 0);
    run_boot(32'h6fff_ffff, 4'h1, 1'b0, 2);
    run_boot(32'h5000_00d8, 4'h0, 1'b1, 2);
    repeat (8) begin
      w = xs();
      run_boot({4'h5, w[27:0]}, w[31:28] & 4'h3, 1'b0, 2);
      repeat (20) drive(1'b1, pick_addr(), w[0]);
    end
    repeat (3) drive(1'b0, 32'h0, 1'b0);
    check(32'(notes.size()), 32'h0);
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock_in);
    bad_count++;
    report_and_stop();
  end
endmodule
